//--- logic/cbm_pkg.sv
// constants, register map and state codes of the beam measurement controller
package cbm_pkg;

	// register subaddresses (8-bit registers)
	localparam logic [7:0] ADDR_MEAS_CTRL   = 8'h20; // bit0 offset check mode
	localparam logic [7:0] ADDR_TUBE_START  = 8'h21; // tube measurement start line
	localparam logic [7:0] ADDR_PIC_LINES   = 8'h22; // picture measurement height in lines
	localparam logic [7:0] ADDR_BRIGHT_SUB  = 8'h23; // brightness used during tube measurement
	localparam logic [7:0] ADDR_WIN_START   = 8'h24; // small window start, units of 4 clocks
	localparam logic [7:0] ADDR_PIC_CTRL    = 8'h25; // picture_measure_control
	localparam logic [7:0] ADDR_WIN_LEN     = 8'h26; // small window length, units of 4 clocks
	localparam logic [7:0] ADDR_CUTLVL_BASE = 8'h28; // 28..2d: lo/hi byte pairs for r, g, b
	localparam logic [7:0] ADDR_RES_CUT_R   = 8'h30; // cutoff red result
	localparam logic [7:0] ADDR_RES_CUT_G   = 8'h31; // cutoff green result
	localparam logic [7:0] ADDR_RES_CUT_B   = 8'h32; // cutoff blue result, read re-arms tube
	localparam logic [7:0] ADDR_RES_WHITE   = 8'h33; // white-drive result
	localparam logic [7:0] ADDR_STATUS      = 8'h34; // measured white colour and busy flags
	localparam logic [7:0] ADDR_RES_PIC_MIN = 8'h35; // picture minimum current
	localparam logic [7:0] ADDR_RES_PIC_MAX = 8'h36; // picture maximum current

	// field positions
	localparam int POS_OFFSET_CHECK = 0; // in ADDR_MEAS_CTRL
	localparam int POS_PIC_BW_LARGE = 0; // in ADDR_PIC_CTRL
	localparam int POS_PIC_WIN_LARGE = 1; // in ADDR_PIC_CTRL
	localparam int POS_PIC_ARM      = 2; // in ADDR_PIC_CTRL, write one to arm

	// reset values
	localparam logic [7:0] RST_TUBE_START = 8'h10; // tube start line
	localparam logic [7:0] RST_PIC_LINES  = 8'h01; // single-line picture measurement
	localparam logic [7:0] RST_BRIGHT_SUB = 8'h80; // mid brightness
	localparam logic [7:0] RST_WIN_START  = 8'h20; // small window start
	localparam logic [7:0] RST_WIN_LEN    = 8'h20; // small window length
	localparam logic [8:0] RST_CUT_LEVEL  = 9'h000; // cutoff levels
	localparam logic [7:0] RST_RESULT     = 8'h00; // result registers

	// timing counts
	localparam int          RED_LINE_OFS  = 2;       // red cutoff line after start line
	localparam logic [1:0]  BCL_TAIL      = 2'd3;    // lines before limiter returns
	localparam logic [8:0]  CONV_LEN_LARGE = 9'd255; // samples per value, 80 kHz setting
	localparam logic [8:0]  CONV_LEN_SMALL = 9'd510; // samples per value, 40 kHz setting

	// tube sequencer states
	typedef enum logic [4:0] {
		TUBE_IDLE  = 5'b00001,
		TUBE_WAIT  = 5'b00010,
		TUBE_CUT   = 5'b00100,
		TUBE_WHITE = 5'b01000,
		TUBE_TAIL  = 5'b10000
	} cbm_tube_e;

	// picture measurement states
	typedef enum logic [2:0] {
		PIC_IDLE = 3'b001,
		PIC_WAIT = 3'b010,
		PIC_RUN  = 3'b100
	} cbm_pic_e;

endpackage : cbm_pkg

//--- logic/cbm_beam_measure.sv
// crt beam current measurement sequencer with converter and register file
// What this block does
// - 8-bit pulse-density converter serves all measurements
// - filter bandwidth selectable 40 or 80 kHz
// - tube measurements in vblank force small bandwidth
// - white-drive measurement drives second range switch
// - picture min/max in window, first range switch
// - cutoff rgb plus one rotating white colour
// - reading blue cutoff result restarts tube measurement
// - cutoff set per field, white set three fields
// - offset check forces stimulus signals to zero
// - tube measurement disables limiter, substitutes brightness
// - red cutoff line is start plus two
// - writing one to bit 2 arms once
// - armed picture measurement runs one field only
// - picture measurement starts at active video start
// - picture height down to one line, bandwidth selectable
// - large window whole active line, tubes use small
// - three 9-bit cutoff levels via registers
`timescale 1ns/10ps
module cbm_beam_measure
	import cbm_pkg::*;
(
	input  wire logic       clk,                       // 40 MHz clock
	input  wire logic       rst_n,                     // async reset, active low
	input  wire logic       pdmBit,                    // converter modulator bit from pin
	input  wire logic       lineStrobe,                // one-cycle pulse at line start
	input  wire logic       fieldStrobe,               // one-cycle pulse at field start
	input  wire logic       activeVideo,               // high during active pixels
	input  wire logic       regWr,                     // register write strobe
	input  wire logic       regRd,                     // register read strobe
	input  wire logic [7:0] regAddr,                   // register subaddress
	input  wire logic [7:0] regWrData,                 // register write data
	output logic      [7:0] regRdData,                 // register read data
	output logic            cutoffStim,                // cutoff stimulus on
	output logic            whiteStim,                 // white-drive stimulus on
	output logic      [1:0] stimColour,                // 0 red, 1 green, 2 blue
	output logic            range_switch_white_drive,  // second range switch
	output logic            range_switch_active_picture, // first range switch
	output logic            filterSmall,               // converter at 40 kHz setting
	output logic            bclDisable,                // average limiter switched off
	output logic      [7:0] brightnessOverride,        // brightness during tube measurement
	output logic            brightnessOverrideOn,      // use brightnessOverride
	output logic      [8:0] cutoffLevelR,              // red dark current level
	output logic      [8:0] cutoffLevelG,              // green dark current level
	output logic      [8:0] cutoffLevelB               // blue dark current level
);

	// pin synchroniser and converter
	logic       pdmMeta;      // first sync stage
	logic       pdmSync;      // second sync stage
	logic [8:0] sampleCnt;    // samples in current value
	logic [8:0] onesAcc;      // ones counted
	logic [7:0] convValue;    // last converted value
	logic       convDone;     // pulse on new value

	// registers
	logic       offsetCheck;  // offset check mode
	logic [7:0] tubeStart;    // tube start line
	logic [7:0] picLines;     // picture height
	logic [7:0] brightSub;    // substitute brightness
	logic [7:0] winStart;     // small window start
	logic [7:0] winLen;       // small window length
	logic       picBwLarge;   // picture bandwidth large
	logic       picWinLarge;  // picture large window
	logic [8:0] cutLevel [3]; // cutoff levels r g b
	logic [7:0] cutRes [3];   // cutoff results r g b
	logic [7:0] whiteRes;     // white-drive result
	logic [1:0] whiteResCol;  // colour of white result
	logic [7:0] picMin;       // picture minimum result
	logic [7:0] picMax;       // picture maximum result

	// timing
	logic [9:0] lineCnt;      // line within field
	logic [11:0] pixCnt;      // clock within line, wide enough for full-length lines
	logic       activePrev;   // active video delayed

	// sequencers
	cbm_tube_e  tubeState;    // tube sequencer state
	cbm_pic_e   picState;     // picture sequencer state
	logic       tubeArmed;    // tube measurement pending
	logic       picArmed;     // picture measurement pending
	logic [1:0] cutIdx;       // cutoff colour in progress
	logic [1:0] whiteCol;     // white colour this field
	logic [1:0] tailCnt;      // lines to limiter return
	logic [7:0] picLeft;      // picture lines left
	logic [7:0] tubeSample;   // last value in small window
	logic [7:0] runMin;       // running minimum
	logic [7:0] runMax;       // running maximum

	// decode and selection
	wire        wrAt       = regWr;
	wire        armWrite   = regWr && regAddr == ADDR_PIC_CTRL && regWrData[POS_PIC_ARM];
	wire        blueRead   = regRd && regAddr == ADDR_RES_CUT_B;
	wire        tubeOn     = tubeState != TUBE_IDLE;
	wire        tubeMeas   = tubeState == TUBE_CUT || tubeState == TUBE_WHITE;
	wire        next_filterSmall = tubeMeas || (tubeOn && tubeState != TUBE_TAIL)
		|| (!tubeOn && !picBwLarge);
	wire [11:0] winLo      = {2'b00, winStart, 2'b00};
	wire [11:0] winHi      = winLo + {2'b00, winLen, 2'b00};
	wire        smallWin   = activeVideo && pixCnt >= winLo && pixCnt < winHi;
	wire        picWin     = picWinLarge ? activeVideo : smallWin;
	wire [9:0]  nextLine   = lineCnt + 10'd1;
	wire [9:0]  redLine    = {2'b00, tubeStart} + 10'(RED_LINE_OFS);
	wire        activeRise = activeVideo && !activePrev;
	wire [8:0]  convLen    = filterSmall ? CONV_LEN_SMALL : CONV_LEN_LARGE;
	wire        convLast   = sampleCnt >= convLen - 9'd1;
	wire [8:0]  onesNext   = onesAcc + {8'h00, pdmSync};
	wire [7:0]  next_convValue = filterSmall ? onesNext[8:1] : onesNext[7:0];
	wire [7:0]  picLinesEff = (picLines == 8'h00) ? 8'h01 : picLines;
	wire        picFinish  = picState == PIC_RUN && (fieldStrobe || (lineStrobe && picLeft <= 8'h01));
	wire [7:0]  winMin     = (convDone && picWin && convValue < runMin) ? convValue : runMin;
	wire [7:0]  winMax     = (convDone && picWin && convValue > runMax) ? convValue : runMax;

	// register read multiplexer
	logic [7:0] rdMux;
	always_comb begin
		rdMux = 8'h00;
		case (regAddr)
			ADDR_MEAS_CTRL:   rdMux = {7'h00, offsetCheck};
			ADDR_TUBE_START:  rdMux = tubeStart;
			ADDR_PIC_LINES:   rdMux = picLines;
			ADDR_BRIGHT_SUB:  rdMux = brightSub;
			ADDR_WIN_START:   rdMux = winStart;
			ADDR_PIC_CTRL:    rdMux = {5'h00, picState != PIC_IDLE || picArmed, picWinLarge, picBwLarge};
			ADDR_WIN_LEN:     rdMux = winLen;
			8'h28:            rdMux = cutLevel[0][7:0];
			8'h29:            rdMux = {7'h00, cutLevel[0][8]};
			8'h2a:            rdMux = cutLevel[1][7:0];
			8'h2b:            rdMux = {7'h00, cutLevel[1][8]};
			8'h2c:            rdMux = cutLevel[2][7:0];
			8'h2d:            rdMux = {7'h00, cutLevel[2][8]};
			ADDR_RES_CUT_R:   rdMux = cutRes[0];
			ADDR_RES_CUT_G:   rdMux = cutRes[1];
			ADDR_RES_CUT_B:   rdMux = cutRes[2];
			ADDR_RES_WHITE:   rdMux = whiteRes;
			ADDR_STATUS:      rdMux = {4'h0, tubeOn, tubeArmed, whiteResCol};
			ADDR_RES_PIC_MIN: rdMux = picMin;
			ADDR_RES_PIC_MAX: rdMux = picMax;
			default:          rdMux = 8'h00; // unmapped reads zero
		endcase
	end

	// two-flop pin synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pdmMeta <= 1'b0;
			pdmSync <= 1'b0;
		end else begin
			pdmMeta <= pdmBit;
			pdmSync <= pdmMeta;
		end
	end

	// pulse-density decimator, counts ones per window
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sampleCnt <= 9'h000;
			onesAcc   <= 9'h000;
			convValue <= 8'h00;
			convDone  <= 1'b0;
		end else if (convLast) begin
			sampleCnt <= 9'h000;
			onesAcc   <= 9'h000;
			convValue <= next_convValue;
			convDone  <= 1'b1;
		end else begin
			sampleCnt <= sampleCnt + 9'h001;
			onesAcc   <= onesNext;
			convDone  <= 1'b0;
		end
	end

	// host writable registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			offsetCheck <= 1'b0;
			tubeStart   <= RST_TUBE_START;
			picLines    <= RST_PIC_LINES;
			brightSub   <= RST_BRIGHT_SUB;
			winStart    <= RST_WIN_START;
			winLen      <= RST_WIN_LEN;
			picBwLarge  <= 1'b0;
			picWinLarge <= 1'b0;
			cutLevel    <= '{RST_CUT_LEVEL, RST_CUT_LEVEL, RST_CUT_LEVEL};
		end else if (wrAt) begin
			case (regAddr)
				ADDR_MEAS_CTRL:  offsetCheck <= regWrData[POS_OFFSET_CHECK];
				ADDR_TUBE_START: tubeStart   <= regWrData;
				ADDR_PIC_LINES:  picLines    <= regWrData;
				ADDR_BRIGHT_SUB: brightSub   <= regWrData;
				ADDR_WIN_START:  winStart    <= regWrData;
				ADDR_WIN_LEN:    winLen      <= regWrData;
				ADDR_PIC_CTRL: begin
					picBwLarge  <= regWrData[POS_PIC_BW_LARGE];
					picWinLarge <= regWrData[POS_PIC_WIN_LARGE];
				end
				8'h28:           cutLevel[0][7:0] <= regWrData;
				8'h29:           cutLevel[0][8]   <= regWrData[0];
				8'h2a:           cutLevel[1][7:0] <= regWrData;
				8'h2b:           cutLevel[1][8]   <= regWrData[0];
				8'h2c:           cutLevel[2][7:0] <= regWrData;
				8'h2d:           cutLevel[2][8]   <= regWrData[0];
				default:         ;                                           // others read-only
			endcase
		end
	end

	// line and pixel counters
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lineCnt    <= 10'h000;
			pixCnt     <= 12'h000;
			activePrev <= 1'b0;
		end else begin
			activePrev <= activeVideo;
			pixCnt     <= lineStrobe ? 12'h000 : pixCnt + 12'h001;
			if (fieldStrobe)
				lineCnt <= 10'h000;
			else if (lineStrobe)
				lineCnt <= nextLine;
		end
	end

	// tube sequencer: wait, cutoff r g b, one white line, limiter tail
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tubeState   <= TUBE_IDLE;
			tubeArmed   <= 1'b1;
			cutIdx      <= 2'd0;
			whiteCol    <= 2'd0;
			tailCnt     <= 2'd0;
			tubeSample  <= 8'h00;
			cutRes      <= '{RST_RESULT, RST_RESULT, RST_RESULT};
			whiteRes    <= RST_RESULT;
			whiteResCol <= 2'd0;
		end else begin
			// blue read sets, field start clears; set wins
			if (blueRead)
				tubeArmed <= 1'b1;
			else if (tubeState == TUBE_IDLE && fieldStrobe)
				tubeArmed <= 1'b0;
			if (convDone && smallWin)
				tubeSample <= convValue;
			case (tubeState)
				TUBE_IDLE: begin
					if (fieldStrobe && tubeArmed)
						tubeState <= TUBE_WAIT;
				end
				TUBE_WAIT: begin
					if (lineStrobe && nextLine == redLine) begin
						tubeState <= TUBE_CUT;
						cutIdx    <= 2'd0;
					end
				end
				TUBE_CUT: begin
					if (lineStrobe) begin
						cutRes[cutIdx] <= tubeSample;
						if (cutIdx == 2'd2)
							tubeState <= TUBE_WHITE;
						else
							cutIdx <= cutIdx + 2'd1;
					end
				end
				TUBE_WHITE: begin
					if (lineStrobe) begin
						whiteRes    <= tubeSample;
						whiteResCol <= whiteCol;
						whiteCol    <= (whiteCol == 2'd2) ? 2'd0 : whiteCol + 2'd1;
						tailCnt     <= BCL_TAIL;
						tubeState   <= TUBE_TAIL;
					end
				end
				TUBE_TAIL: begin
					if (lineStrobe) begin
						if (tailCnt <= 2'd1)
							tubeState <= TUBE_IDLE;
						tailCnt <= tailCnt - 2'd1;
					end
				end
				default: tubeState <= TUBE_IDLE;
			endcase
		end
	end

	// picture sequencer: one field per arm, from first active video
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			picState <= PIC_IDLE;
			picArmed <= 1'b0;
			picLeft  <= 8'h00;
			runMin   <= 8'hff;
			runMax   <= 8'h00;
			picMin   <= RST_RESULT;
			picMax   <= RST_RESULT;
		end else begin
			// arm write sets, field start clears; set wins
			if (armWrite)
				picArmed <= 1'b1;
			else if (picState == PIC_IDLE && fieldStrobe)
				picArmed <= 1'b0;
			case (picState)
				PIC_IDLE: begin
					if (fieldStrobe && picArmed)
						picState <= PIC_WAIT;
				end
				PIC_WAIT: begin
					runMin <= 8'hff;
					runMax <= 8'h00;
					if (activeRise) begin
						picState <= PIC_RUN;
						picLeft  <= picLinesEff;
					end
				end
				PIC_RUN: begin
					runMin <= winMin;
					runMax <= winMax;
					if (picFinish) begin
						picMin   <= winMin;
						picMax   <= winMax;
						picState <= PIC_IDLE;
					end else if (lineStrobe)
						picLeft <= picLeft - 8'h01;
				end
				default: picState <= PIC_IDLE;
			endcase
		end
	end

	// registered outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData                   <= 8'h00;
			cutoffStim                  <= 1'b0;
			whiteStim                   <= 1'b0;
			stimColour                  <= 2'd0;
			range_switch_white_drive    <= 1'b0;
			range_switch_active_picture <= 1'b0;
			filterSmall                 <= 1'b1;
			bclDisable                  <= 1'b0;
			brightnessOverride          <= RST_BRIGHT_SUB;
			brightnessOverrideOn        <= 1'b0;
			cutoffLevelR                <= RST_CUT_LEVEL;
			cutoffLevelG                <= RST_CUT_LEVEL;
			cutoffLevelB                <= RST_CUT_LEVEL;
		end else begin
			regRdData                   <= rdMux;
			cutoffStim                  <= tubeState == TUBE_CUT && !offsetCheck;
			whiteStim                   <= tubeState == TUBE_WHITE && !offsetCheck;
			stimColour                  <= tubeState == TUBE_WHITE ? whiteCol : cutIdx;
			range_switch_white_drive    <= tubeState == TUBE_WHITE;
			range_switch_active_picture <= picState == PIC_RUN;
			filterSmall                 <= next_filterSmall;
			bclDisable                  <= tubeState != TUBE_IDLE && tubeState != TUBE_WAIT;
			brightnessOverride          <= brightSub;
			brightnessOverrideOn        <= tubeMeas;
			cutoffLevelR                <= cutLevel[0];
			cutoffLevelG                <= cutLevel[1];
			cutoffLevelB                <= cutLevel[2];
		end
	end

endmodule : cbm_beam_measure

//--- testbench/cbm_beam_measure_sva.sv
// port-level assertion checker for the beam measurement controller
`timescale 1ns/10ps
module cbm_beam_measure_sva
	import cbm_pkg::*;
(
	input wire logic       clk,                         // clock
	input wire logic       rst_n,                       // async reset, active low
	input wire logic       activeVideo,                 // active pixels
	input wire logic       regWr,                       // write strobe
	input wire logic [7:0] regAddr,                     // subaddress
	input wire logic [7:0] regWrData,                   // write data
	input wire logic       cutoffStim,                  // cutoff stimulus
	input wire logic       whiteStim,                   // white stimulus
	input wire logic [1:0] stimColour,                  // stimulus colour
	input wire logic       range_switch_white_drive,    // second range switch
	input wire logic       range_switch_active_picture, // first range switch
	input wire logic       filterSmall,                 // 40 kHz setting
	input wire logic       bclDisable,                  // limiter off
	input wire logic [7:0] brightnessOverride,          // substitute brightness
	input wire logic       brightnessOverrideOn,        // substitute in use
	input wire logic [8:0] cutoffLevelR                 // red dark level
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic offsetMode; // shadow of the offset check bit

	// follow host writes of the mode register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			offsetMode <= 1'b0;
		end else if (regWr && regAddr == ADDR_MEAS_CTRL) begin
			offsetMode <= regWrData[POS_OFFSET_CHECK];
		end
	end

	a_white_range_sw: assert property (whiteStim |-> range_switch_white_drive)
		else $error("white line without second range switch");
	a_tube_small_bw: assert property ((cutoffStim || whiteStim) |-> filterSmall)
		else $error("tube line without small bandwidth");
	a_tube_bcl_off: assert property ((cutoffStim && $past(cutoffStim)) |->
		bclDisable && brightnessOverrideOn)
		else $error("limiter active during cutoff line");
	a_bright_value: assert property (regWr && regAddr == ADDR_BRIGHT_SUB |->
		##2 brightnessOverride == $past(regWrData, 2))
		else $error("substitute brightness not taken");
	a_cut_level_lo: assert property (regWr && regAddr == ADDR_CUTLVL_BASE |->
		##2 cutoffLevelR[7:0] == $past(regWrData, 2))
		else $error("red cutoff level low byte not taken");
	a_red_first: assert property ($rose(cutoffStim) |-> stimColour == 2'd0)
		else $error("cutoff sequence not starting with red");
	a_white_after_blue: assert property ($rose(whiteStim) |->
		$past(cutoffStim) && $past(stimColour) == 2'd2)
		else $error("white line not right after blue cutoff");
	a_bcl_tail: assert property ($fell(range_switch_white_drive) |->
		bclDisable [*3])
		else $error("limiter back too soon after white line");
	a_offset_no_stim: assert property (offsetMode && $past(offsetMode) |-> !cutoffStim && !whiteStim)
		else $error("stimulus active in offset check");
	a_pic_in_video: assert property ($rose(range_switch_active_picture) |->
		activeVideo)
		else $error("picture measurement outside active video");
endmodule : cbm_beam_measure_sva

bind cbm_beam_measure cbm_beam_measure_sva cbm_beam_measure_sva_inst (
	.clk(clk), .rst_n(rst_n), .activeVideo(activeVideo), .regWr(regWr),
	.regAddr(regAddr), .regWrData(regWrData), .cutoffStim(cutoffStim),
	.whiteStim(whiteStim), .stimColour(stimColour),
	.range_switch_white_drive(range_switch_white_drive),
	.range_switch_active_picture(range_switch_active_picture),
	.filterSmall(filterSmall), .bclDisable(bclDisable),
	.brightnessOverride(brightnessOverride),
	.brightnessOverrideOn(brightnessOverrideOn), .cutoffLevelR(cutoffLevelR)
);

//--- testbench/cbm_host_model.sv
// control processor model driving the register port
`timescale 1ns/10ps
module cbm_host_model
	import cbm_pkg::*;
(
	input  wire logic       clk,       // system clock
	output logic            regWr,     // write strobe
	output logic            regRd,     // read strobe
	output logic      [7:0] regAddr,   // subaddress
	output logic      [7:0] regWrData, // write data
	input  wire logic [7:0] regRdData  // read data
);
	// idle bus at time zero
	initial begin
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
	end

	// one write, strobe held for exactly one edge
	task automatic wrReg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		#2;
		regAddr = addr;
		regWrData = data;
		regWr = 1'b1;
		@(posedge clk);
		#2;
		regWr = 1'b0;
		regWrData = ~data; // released data no longer valid
	endtask : wrReg

	// one read, data taken one edge after the strobe
	task automatic rdReg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk);
		#2;
		regAddr = addr;
		regRd = 1'b1;
		@(posedge clk);
		#2;
		regRd = 1'b0;
		@(posedge clk);
		#1;
		data = regRdData;
	endtask : rdReg

	// each arming write sets the pending arm; repeated writes before the next field start start only one picture measurement
	task automatic armPicture(input logic [7:0] ctrl);
		wrReg(ADDR_PIC_CTRL, ctrl | 8'h04);
	endtask : armPicture
endmodule : cbm_host_model

//--- testbench/tb_top.sv
// self-checking testbench for the beam measurement controller
`timescale 1ns/10ps
module tb_top;
	import cbm_pkg::*;
	localparam int LINE_LEN    = 1500; // clocks per line
	localparam int FIELD_LINES = 10;   // lines per field

	logic       clk, rst_n, pdmBit, lineStrobe, fieldStrobe, activeVideo;
	logic       regWr, regRd, cutoffStim, whiteStim, rswWhite, rswPic;
	logic       filterSmall, bclDisable, overrideOn, videoOn, picHigh, cutPrev;
	logic [7:0] regAddr, regWrData, regRdData, brightOvr;
	logic [1:0] stimColour;
	logic [8:0] levelR, levelG, levelB;
	int         pix, lineCnt, redLine, nErrors, nTests;

	cbm_beam_measure cbm_beam_measure_inst (
		.clk(clk), .rst_n(rst_n), .pdmBit(pdmBit), .lineStrobe(lineStrobe),
		.fieldStrobe(fieldStrobe), .activeVideo(activeVideo), .regWr(regWr),
		.regRd(regRd), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData(regRdData), .cutoffStim(cutoffStim), .whiteStim(whiteStim),
		.stimColour(stimColour), .range_switch_white_drive(rswWhite),
		.range_switch_active_picture(rswPic), .filterSmall(filterSmall),
		.bclDisable(bclDisable), .brightnessOverride(brightOvr),
		.brightnessOverrideOn(overrideOn), .cutoffLevelR(levelR),
		.cutoffLevelG(levelG), .cutoffLevelB(levelB)
	);

	cbm_host_model cbm_host_model_inst (
		.clk(clk), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData(regRdData)
	);

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// video timing and sense input, driven just after each edge
	always @(posedge clk) begin
		#2;
		pdmBit = cutoffStim | whiteStim | (rswPic & picHigh); // current follows stimulus
		if (videoOn) begin
			pix = (pix == LINE_LEN - 1) ? 0 : pix + 1;
			if (pix == 0) begin
				lineCnt = (lineCnt == FIELD_LINES - 1) ? 0 : lineCnt + 1;
			end
			lineStrobe = (pix == 0);
			fieldStrobe = (pix == 0) && (lineCnt == 0);
			activeVideo = (pix >= 8) && (pix < LINE_LEN - 10);
		end
	end

	// note the line on which the cutoff stimulus starts
	always @(posedge clk) begin
		#1;
		if (cutoffStim && !cutPrev) begin
			redLine = lineCnt;
		end
		cutPrev = cutoffStim;
	end

	// compare and count
	task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
		nTests++;
		if (got !== exp) begin
			nErrors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// read a register and compare the masked bits
	task automatic rdChk(input logic [7:0] addr, input logic [7:0] mask, input logic [7:0] exp);
		logic [7:0] d;
		cbm_host_model_inst.rdReg(addr, d);
		check($sformatf("register %h", addr), {1'b0, exp}, {1'b0, d & mask});
	endtask : rdChk

	// wait for field starts
	task automatic waitFields(input int n);
		repeat (n) @(posedge clk iff fieldStrobe);
	endtask : waitFields

	// verdict and end of run
	task automatic completeRun();
		$display("checks %0d mismatches %0d", nTests, nErrors);
		if (nErrors == 0 && nTests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : completeRun

	// watchdog well past the five fields of traffic
	initial begin
		repeat (90000) @(posedge clk);
		nErrors++;
		$display("MISMATCH watchdog expected end seen timeout");
		completeRun();
	end

	// main sequence
	initial begin
		{rst_n, pdmBit, lineStrobe, fieldStrobe, activeVideo, videoOn, cutPrev} = 7'h00;
		picHigh = 1'b1;
		pix = LINE_LEN - 1;
		lineCnt = FIELD_LINES - 1;
		{redLine, nErrors, nTests} = 0;
		repeat (10) @(posedge clk);
		#2;
		rst_n = 1'b1;
		rdChk(ADDR_TUBE_START, 8'hff, RST_TUBE_START);
		rdChk(ADDR_PIC_LINES, 8'hff, RST_PIC_LINES);
		rdChk(ADDR_BRIGHT_SUB, 8'hff, RST_BRIGHT_SUB);
		rdChk(ADDR_RES_PIC_MAX, 8'hff, RST_RESULT);
		rdChk(8'h27, 8'hff, 8'h00);
		rdChk(ADDR_STATUS, 8'h04, 8'h04);
		check("filter small", 9'h001, {8'h00, filterSmall});
		$display("test reset values done");
		cbm_host_model_inst.wrReg(ADDR_TUBE_START, 8'h01);
		cbm_host_model_inst.wrReg(ADDR_WIN_START, 8'h90);
		cbm_host_model_inst.wrReg(ADDR_WIN_LEN, 8'hff);
		cbm_host_model_inst.wrReg(ADDR_BRIGHT_SUB, 8'h4d);
		cbm_host_model_inst.wrReg(ADDR_CUTLVL_BASE, 8'h5a);
		cbm_host_model_inst.wrReg(ADDR_CUTLVL_BASE + 8'h01, 8'h01);
		cbm_host_model_inst.wrReg(ADDR_CUTLVL_BASE + 8'h02, 8'h3c);
		cbm_host_model_inst.wrReg(ADDR_CUTLVL_BASE + 8'h04, 8'hff);
		cbm_host_model_inst.wrReg(ADDR_CUTLVL_BASE + 8'h05, 8'h01);
		cbm_host_model_inst.wrReg(ADDR_RES_CUT_R, 8'h77);
		rdChk(ADDR_RES_CUT_R, 8'hff, 8'h00);
		rdChk(ADDR_TUBE_START, 8'hff, 8'h01);
		check("levelR", 9'h15a, levelR);
		check("levelG", 9'h03c, levelG);
		check("levelB", 9'h1ff, levelB);
		check("brightness", 9'h04d, {1'b0, brightOvr});
		cbm_host_model_inst.armPicture(8'h01);
		rdChk(ADDR_PIC_CTRL, 8'h04, 8'h04);
		check("filter large", 9'h000, {8'h00, filterSmall});
		$display("test setup done");
		videoOn = 1'b1;
		waitFields(2);
		rdChk(ADDR_RES_CUT_R, 8'hff, 8'hff);
		rdChk(ADDR_RES_CUT_G, 8'hff, 8'hff);
		rdChk(ADDR_RES_WHITE, 8'hff, 8'hff);
		rdChk(ADDR_STATUS, 8'h07, 8'h00);
		rdChk(ADDR_RES_PIC_MIN, 8'hff, 8'hff);
		rdChk(ADDR_RES_PIC_MAX, 8'hff, 8'hff);
		rdChk(ADDR_PIC_CTRL, 8'h04, 8'h00);
		check("red line", 9'd3, redLine[8:0]);
		rdChk(ADDR_RES_CUT_B, 8'hff, 8'hff);
		rdChk(ADDR_STATUS, 8'h04, 8'h04);
		cbm_host_model_inst.wrReg(ADDR_MEAS_CTRL, 8'h01);
		picHigh = 1'b0;
		cbm_host_model_inst.armPicture(8'h01);
		$display("test first field done");
		waitFields(2);
		rdChk(ADDR_RES_CUT_R, 8'hff, 8'h00);
		rdChk(ADDR_RES_WHITE, 8'hff, 8'h00);
		rdChk(ADDR_STATUS, 8'h03, 8'h01);
		rdChk(ADDR_RES_PIC_MIN, 8'hff, 8'h00);
		rdChk(ADDR_RES_PIC_MAX, 8'hff, 8'h00);
		cbm_host_model_inst.wrReg(ADDR_MEAS_CTRL, 8'h00);
		rdChk(ADDR_RES_CUT_B, 8'hff, 8'h00);
		$display("test offset check done");
		waitFields(2);
		rdChk(ADDR_RES_CUT_R, 8'hff, 8'hff);
		rdChk(ADDR_RES_WHITE, 8'hff, 8'hff);
		rdChk(ADDR_STATUS, 8'h03, 8'h02);
		rdChk(ADDR_RES_PIC_MAX, 8'hff, 8'h00);
		rdChk(ADDR_PIC_CTRL, 8'h04, 8'h00);
		$display("test rotation done");
		completeRun();
	end
endmodule : tb_top
